// [rtl/motion_seq_pkg.sv]
package motion_seq_pkg;
	localparam int PROG_AW    = 8;
	localparam int CALL_DEPTH = 4;
	localparam int LOOP_DEPTH = 3;
	localparam int NUM_GPREG  = 8;
	// timing: delay unit 10 ms at a 10 ns clock
	localparam longint DELAY_UNIT_NS = 10_000_000;
	localparam longint CLK_PERIOD_NS = 10;
	localparam int TICK_CYCLES = int'(DELAY_UNIT_NS / CLK_PERIOD_NS);
	localparam logic [18:0] DELAY_MIN = 19'h0_0001;
	localparam logic [18:0] DELAY_MAX = 19'h1_86A0;
	localparam logic [14:0] LOOP_MIN  = 15'h0001;
	localparam logic [14:0] LOOP_MAX  = 15'h2710;
	localparam logic [31:0] RATIO_MIN = 32'h0000_0001;
	localparam logic [31:0] RATIO_MAX = 32'h000F_423F;
	localparam logic [23:0] PCT_DIV   = 24'h00_0064;
	localparam logic [31:0] LIM_LO_RST = 32'h8000_0000;
	localparam logic [31:0] LIM_HI_RST = 32'h7FFF_FFFF;
	localparam logic [19:0] RATIO_RST  = 20'h0_2710;
	// apb byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_PADDR  = 8'h08;
	localparam logic [7:0] OFS_PDATA  = 8'h0C;
	localparam logic [7:0] OFS_OUTS   = 8'h10;
	localparam logic [7:0] OFS_FLAGS  = 8'h14;
	localparam logic [7:0] OFS_GPREG  = 8'h40;
	localparam int CTRL_START = 0;
	localparam int CTRL_CLR   = 1;
	localparam int CTRL_STOP  = 2;
	typedef enum logic [4:0] {
		OP_NOP = 5'h00, OP_SET_OUT = 5'h01, OP_SET_FLAG = 5'h02, OP_MULTI = 5'h03,
		OP_BRANCH = 5'h04, OP_BR_COND = 5'h05, OP_CALL = 5'h06, OP_CALL_COND = 5'h07,
		OP_RETURN = 5'h08, OP_BR_POS = 5'h09, OP_BR_ANALOG = 5'h0A, OP_BR_REG = 5'h0B,
		OP_LOOP_START = 5'h0C, OP_LOOP_END = 5'h0D, OP_WAIT = 5'h0E, OP_DELAY = 5'h0F,
		OP_END = 5'h10, OP_TORQUE = 5'h11, OP_PARAM = 5'h12
	} opcode_e;
	typedef enum logic [2:0] {
		CMP_LT = 3'h0, CMP_GT = 3'h1, CMP_LE = 3'h2, CMP_GE = 3'h3, CMP_NE = 3'h4,
		CMP_EQ = 3'h5
	} cmp_e;
	localparam logic [2:0] PAR_FOLLOW = 3'h0;
	localparam logic [2:0] PAR_INPOS  = 3'h1;
	localparam logic [2:0] PAR_LIM_LO = 3'h2;
	localparam logic [2:0] PAR_LIM_HI = 3'h3;
	localparam logic [2:0] PAR_RATIO  = 3'h4;
	typedef struct packed {
		logic [4:0]  op;      // 31:27
		logic [2:0]  sub;     // compare type, parameter select, flag block
		logic        use_reg; // operand from register
		logic [2:0]  rsel;    // register select / position source
		logic [11:0] imm;     // constant or condition select
		logic [7:0]  label;   // target address or bit index
	} instr_s;
endpackage

// [rtl/motion_program_sequencer.sv]
// Overview of operation
// [RULE1] set/clear one of eight outputs
// [RULE2] plc output state overrides program state
// [RULE3] set/clear one of 32 flags
// [RULE4] block of 8 or 16 flags updates together
// [RULE5] each flag: set, clear or unchanged
// [RULE6] branch loads pc with label
// [RULE7] conditional branch on input/flag level
// [RULE8] call pushes return address, four deep
// [RULE9] return pops and resumes after call
// [RULE10] conditional call only when condition matches
// [RULE11] position compare branch, six comparisons
// [RULE12] analog compare branch
// [RULE13] register compare branch
// [RULE14] loop count from 1 to 10000
// [RULE15] three nested loops, own count, start
// [RULE16] loop end jumps back until count done
// [RULE17] wait on input/flag, optional jog
// [RULE18] delay 10 ms to 1000 s
// [RULE19] end stops, pulses one-cycle status bit
// [RULE20] torque limit as percent of configured
// [RULE21] override follow error, band, soft limits
// [RULE22] follow ratio 0.0001 to 99.9999
// [RULE23] nesting overflow or underflow halts with fault
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module motion_program_sequencer import motion_seq_pkg::*; #(
	parameter int TICKS = TICK_CYCLES // cycles per delay unit
) (
	input  wire logic        pclk,                  // clock
	input  wire logic        presetn,               // async reset, low
	input  wire logic        psel,                  // apb select
	input  wire logic        penable,               // apb enable
	input  wire logic        pwrite,                // apb direction
	input  wire logic [7:0]  paddr,                 // apb address
	input  wire logic [31:0] pwdata,                // apb write data
	output logic      [31:0] prdata,                // apb read data
	output logic             pready,                // apb ready
	output logic             pslverr,               // apb error
	input  wire logic [31:0] phys_in,               // physical inputs
	input  wire logic [31:0] plc_flags,             // plc to sequencer flags
	input  wire logic [7:0]  plc_out_en,            // plc owns output
	input  wire logic [7:0]  plc_out_val,           // plc output state
	input  wire logic [31:0] actual_pos,            // actual position
	input  wire logic [31:0] cmd_pos,               // commanded position
	input  wire logic [15:0] analog_in,             // analog reading
	input  wire logic [15:0] torque_cfg,            // configured torque limit
	input  wire logic [31:0] global_follow,         // global following error
	input  wire logic [31:0] global_inpos,          // global in-position band
	output logic      [7:0]  phys_out,              // physical outputs
	output logic      [31:0] seq_flags,             // sequencer to plc flags
	output logic             program_end_pulse_bit, // end one-shot
	output logic             running,               // program active
	output logic             fault,                 // sticky fault
	output logic             jog_enable,            // jog allowed in wait
	output logic      [15:0] torque_limit,          // active torque limit
	output logic      [31:0] follow_limit,          // active following error
	output logic      [31:0] inpos_band,            // active in-position band
	output logic      [31:0] soft_lim_lo,           // soft travel low
	output logic      [31:0] soft_lim_hi,           // soft travel high
	output logic      [19:0] follow_ratio           // ratio, 0.0001 units
);
	typedef enum logic [4:0] {
		S_IDLE = 5'b00001, S_FETCH = 5'b00010, S_EXEC = 5'b00100,
		S_HOLD = 5'b01000, S_DELAY = 5'b10000
	} state_e;

	function automatic logic compare(input logic signed [31:0] a,
		input logic signed [31:0] b, input logic [2:0] kind);
		case (kind)
			CMP_LT:  return a < b;
			CMP_GT:  return a > b;
			CMP_LE:  return a <= b;
			CMP_GE:  return a >= b;
			CMP_NE:  return a != b;
			CMP_EQ:  return a == b;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] sext12(input logic [11:0] v);
		return {{20{v[11]}}, v};
	endfunction

	logic [31:0]        prog [2**PROG_AW];
	logic [31:0]        gpreg [NUM_GPREG];
	logic [PROG_AW-1:0] prog_addr;
	logic [PROG_AW-1:0] pc;
	logic [PROG_AW-1:0] call_stk [CALL_DEPTH];
	logic [2:0]         sp;
	logic [PROG_AW-1:0] loop_start [LOOP_DEPTH];
	logic [14:0]        loop_cnt [LOOP_DEPTH];
	logic [1:0]         lsp;
	logic [18:0]        delay_units;
	logic [31:0]        tick;
	instr_s             ir;
	state_e             state;
	logic [7:0]         seq_out;
	logic               torque_ovr, follow_ovr, inpos_ovr;
	logic [15:0]        torque_val;
	logic [31:0]        follow_val, inpos_val;

	// apb decode
	logic        wr, setup, start_req, clr_req, stop_req;
	logic [31:0] rd_val;
	logic        rd_err;
	assign setup     = psel && !penable;
	assign wr        = psel && penable && pwrite;
	assign start_req = wr && paddr == OFS_CTRL && pwdata[CTRL_START];
	assign clr_req   = wr && paddr == OFS_CTRL && pwdata[CTRL_CLR];
	assign stop_req  = wr && paddr == OFS_CTRL && pwdata[CTRL_STOP];
	assign pready    = 1'b1;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (paddr >= OFS_GPREG && paddr < OFS_GPREG + 8'(4 * NUM_GPREG) && paddr[1:0] == 2'b00)
			rd_val = gpreg[3'(paddr[7:2])];
		else case (paddr)
			OFS_CTRL:   rd_val = 32'h0000_0000;
			OFS_STATUS: rd_val = {16'h0000, 8'(pc), 5'h00, jog_enable, fault, running};
			OFS_PADDR:  rd_val = 32'(prog_addr);
			OFS_PDATA:  rd_val = prog[prog_addr];
			OFS_OUTS:   rd_val = {24'h00_0000, phys_out};
			OFS_FLAGS:  rd_val = seq_flags;
			default:    rd_err = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_val;
			pslverr <= rd_err;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_addr <= '0;
		end else if (wr && paddr == OFS_PADDR) begin
			prog_addr <= pwdata[PROG_AW-1:0];
		end else if (wr && paddr == OFS_PDATA) begin
			prog_addr <= prog_addr + 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (wr && paddr == OFS_PDATA)
			prog[prog_addr] <= pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_GPREG; i++)
				gpreg[i] <= 32'h0000_0000;
		end else if (wr && paddr >= OFS_GPREG && paddr < OFS_GPREG + 8'(4 * NUM_GPREG)) begin
			gpreg[3'(paddr[7:2])] <= pwdata;
		end
	end

	// instruction decode
	logic        exec, cond, cmp_hit, bad;
	logic [31:0] opnd, opnd_b, ratio_v, regb_v;
	logic [14:0] loop_n;
	logic [18:0] delay_n;
	logic [PROG_AW-1:0] pc_next;
	assign exec    = state == S_EXEC;
	assign pc_next = pc + 1'b1;
	assign opnd    = ir.use_reg ? gpreg[ir.rsel] : sext12(ir.imm);
	assign regb_v  = gpreg[ir.imm[2:0]];
	assign opnd_b  = ir.use_reg ? regb_v : sext12(ir.imm);
	assign loop_n  = {ir.sub, ir.imm};
	assign delay_n = {ir.sub, ir.use_reg, ir.rsel, ir.imm};
	assign ratio_v = opnd;
	// condition: imm[0] flag/input, imm[5:1] index, imm[6] level
	assign cond = (ir.imm[0] ? plc_flags[ir.imm[5:1]] : phys_in[ir.imm[5:1]]) == ir.imm[6];

	always_comb begin
		cmp_hit = 1'b0;
		case (ir.op)
			OP_BR_POS:    cmp_hit = compare(ir.rsel[0] ? actual_pos : cmd_pos, opnd_b, ir.sub); // see [RULE11]
			OP_BR_ANALOG: cmp_hit = compare(32'(signed'(analog_in)), opnd, ir.sub); // see [RULE12]
			OP_BR_REG:    cmp_hit = compare(gpreg[ir.rsel], opnd_b, ir.sub); // see [RULE13]
			default:      cmp_hit = 1'b0;
		endcase
	end

	always_comb begin
		case (ir.op)
			OP_CALL:       bad = sp == 3'(CALL_DEPTH); // see [RULE23]
			OP_CALL_COND:  bad = cond && sp == 3'(CALL_DEPTH);
			OP_RETURN:     bad = sp == 3'h0;
			OP_LOOP_START: bad = lsp == 2'(LOOP_DEPTH) || loop_n < LOOP_MIN || loop_n > LOOP_MAX;
			OP_LOOP_END:   bad = lsp == 2'h0;
			OP_DELAY:      bad = delay_n < DELAY_MIN || delay_n > DELAY_MAX;
			OP_PARAM:      bad = ir.sub == PAR_RATIO && (ratio_v < RATIO_MIN || ratio_v > RATIO_MAX);
			OP_NOP, OP_SET_OUT, OP_SET_FLAG, OP_MULTI, OP_BRANCH, OP_BR_COND, OP_BR_POS,
			OP_BR_ANALOG, OP_BR_REG, OP_WAIT, OP_END, OP_TORQUE: bad = 1'b0;
			default:       bad = 1'b1;
		endcase
	end

	// sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			pc    <= '0;
			ir    <= '0;
			sp    <= 3'h0;
			lsp   <= 2'h0;
			for (int i = 0; i < CALL_DEPTH; i++)
				call_stk[i] <= '0;
			for (int i = 0; i < LOOP_DEPTH; i++) begin
				loop_start[i] <= '0;
				loop_cnt[i]   <= 15'h0000;
			end
		end else if (stop_req) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE: if (start_req && !fault) begin
					pc    <= '0;
					sp    <= 3'h0;
					lsp   <= 2'h0;
					state <= S_FETCH;
				end
				S_FETCH: begin
					ir    <= prog[pc];
					state <= S_EXEC;
				end
				S_EXEC: begin
					state <= S_FETCH;
					pc    <= pc_next;
					if (bad) begin
						state <= S_IDLE; // see [RULE23]
					end else case (ir.op)
						OP_BRANCH: pc <= ir.label; // see [RULE6]
						OP_BR_COND: if (cond) pc <= ir.label; // see [RULE7]
						OP_BR_POS, OP_BR_ANALOG, OP_BR_REG: if (cmp_hit) pc <= ir.label;
						OP_CALL, OP_CALL_COND: if (ir.op == OP_CALL || cond) begin
							call_stk[sp[1:0]] <= pc_next; // see [RULE8] [RULE10]
							sp <= sp + 3'h1;
							pc <= ir.label;
						end
						OP_RETURN: begin
							pc <= call_stk[2'(sp - 3'h1)]; // see [RULE9]
							sp <= sp - 3'h1;
						end
						OP_LOOP_START: begin
							loop_start[lsp] <= pc_next; // see [RULE14] [RULE15]
							loop_cnt[lsp]   <= loop_n;
							lsp <= lsp + 2'h1;
						end
						OP_LOOP_END: if (loop_cnt[2'(lsp - 2'h1)] > 15'h0001) begin
							loop_cnt[2'(lsp - 2'h1)] <= loop_cnt[2'(lsp - 2'h1)] - 15'h0001;
							pc <= loop_start[2'(lsp - 2'h1)]; // see [RULE16]
						end else begin
							lsp <= lsp - 2'h1;
						end
						OP_WAIT: begin
							pc    <= pc;
							state <= S_HOLD;
						end
						OP_DELAY: begin
							pc    <= pc;
							state <= S_DELAY;
						end
						OP_END: state <= S_IDLE; // see [RULE19]
						default: ;
					endcase
				end
				S_HOLD: if (cond) begin
					pc    <= pc_next; // see [RULE17]
					state <= S_FETCH;
				end
				S_DELAY: if (delay_units == 19'h0_0000) begin
					pc    <= pc_next; // see [RULE18]
					state <= S_FETCH;
				end
			endcase
		end
	end

	// delay timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_units <= 19'h0_0000;
			tick        <= 32'h0000_0000;
		end else if (exec && ir.op == OP_DELAY) begin
			delay_units <= delay_n; // see [RULE18]
			tick        <= 32'(TICKS - 1);
		end else if (state == S_DELAY && delay_units != 19'h0_0000) begin
			if (tick == 32'h0000_0000) begin
				tick        <= 32'(TICKS - 1);
				delay_units <= delay_units - 19'h0_0001;
			end else begin
				tick <= tick - 32'h0000_0001;
			end
		end
	end

	assign running    = state != S_IDLE;
	assign jog_enable = state == S_HOLD && ir.imm[7]; // see [RULE17]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault                 <= 1'b0;
			program_end_pulse_bit <= 1'b0;
		end else begin
			fault <= (exec && bad) || (fault && !clr_req); // see [RULE23]
			program_end_pulse_bit <= exec && !bad && ir.op == OP_END && !stop_req; // see [RULE19]
		end
	end

	// outputs and flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_out   <= 8'h00;
			seq_flags <= 32'h0000_0000;
		end else if (exec && !stop_req) begin
			if (ir.op == OP_SET_OUT)
				seq_out[ir.label[2:0]] <= ir.imm[0]; // see [RULE1]
			if (ir.op == OP_SET_FLAG)
				seq_flags[ir.label[4:0]] <= ir.imm[0]; // see [RULE3]
			// mask in reg[31:16], value in reg[15:0]; unmasked bits stay
			if (ir.op == OP_MULTI) begin
				for (int i = 0; i < 16; i++) begin
					if (gpreg[ir.rsel][16 + i] && (ir.sub[0] || i < 8)) begin
						if (ir.sub[0])
							seq_flags[{ir.sub[1], 4'(i)}] <= gpreg[ir.rsel][i]; // see [RULE4]
						else
							seq_flags[{ir.sub[2:1], 3'(i)}] <= gpreg[ir.rsel][i]; // see [RULE5]
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			phys_out <= 8'h00;
		else
			phys_out <= (plc_out_en & plc_out_val) | (~plc_out_en & seq_out); // see [RULE2]
	end

	// parameter changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_ovr   <= 1'b0;
			follow_ovr   <= 1'b0;
			inpos_ovr    <= 1'b0;
			torque_val   <= 16'h0000;
			follow_val   <= 32'h0000_0000;
			inpos_val    <= 32'h0000_0000;
			soft_lim_lo  <= LIM_LO_RST;
			soft_lim_hi  <= LIM_HI_RST;
			follow_ratio <= RATIO_RST;
		end else if (exec && !bad && !stop_req) begin
			if (ir.op == OP_TORQUE) begin
				torque_ovr <= 1'b1;
				torque_val <= 16'((24'(torque_cfg) * 24'(opnd[7:0])) / PCT_DIV); // see [RULE20]
			end
			if (ir.op == OP_PARAM) begin
				case (ir.sub)
					PAR_FOLLOW: begin
						follow_ovr <= 1'b1;
						follow_val <= opnd; // see [RULE21]
					end
					PAR_INPOS: begin
						inpos_ovr <= 1'b1;
						inpos_val <= opnd;
					end
					PAR_LIM_LO: soft_lim_lo <= opnd;
					PAR_LIM_HI: soft_lim_hi <= opnd;
					PAR_RATIO:  follow_ratio <= ratio_v[19:0]; // see [RULE22]
					default: ;
				endcase
			end
		end
	end

	assign torque_limit = torque_ovr ? torque_val : torque_cfg;
	assign follow_limit = follow_ovr ? follow_val : global_follow;
	assign inpos_band   = inpos_ovr ? inpos_val : global_inpos;

	// checks
	sequence end_exec;
		exec && !bad && ir.op == OP_END && !stop_req;
	endsequence
	a_end_pulse_once: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE19]
		end_exec |=> program_end_pulse_bit && state == S_IDLE ##1 !program_end_pulse_bit)
		else $error("end pulse wrong");
	a_plc_override: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE2]
		plc_out_en != 8'h00 |=>
		((phys_out ^ $past(plc_out_val)) & $past(plc_out_en)) == 8'h00)
		else $error("plc override lost");
	a_branch_target: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE6]
		exec && !stop_req && ir.op == OP_BRANCH |=> pc == $past(ir.label) && state == S_FETCH)
		else $error("branch target wrong");
	a_call_depth: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE8]
		sp <= 3'(CALL_DEPTH) && lsp <= 2'(LOOP_DEPTH))
		else $error("stack depth exceeded");
	a_call_return: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE9]
		exec && !stop_req && ir.op == OP_CALL && !bad ##1 state == S_FETCH ##1
		exec && !stop_req && ir.op == OP_RETURN |=> pc == $past(pc, 3) + 1'b1)
		else $error("return address wrong");
	a_fault_halts: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE23]
		exec && bad && !stop_req |=> fault && state == S_IDLE)
		else $error("fault not raised");
	a_wait_stalls: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE17]
		state == S_HOLD && !cond && !stop_req |=> state == S_HOLD && $stable(pc))
		else $error("wait advanced early");
	a_delay_holds: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE18]
		exec && !stop_req && ir.op == OP_DELAY && !bad |=> state == S_DELAY [*2])
		else $error("delay too short");
	a_loop_back: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE16]
		exec && !stop_req && ir.op == OP_LOOP_END && lsp != 2'h0 &&
		loop_cnt[2'(lsp - 2'h1)] > 15'h0001 |=> pc == $past(loop_start[2'(lsp - 2'h1)]))
		else $error("loop did not repeat");
	a_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // see [RULE3]
		exec && !stop_req && ir.op == OP_SET_FLAG |=>
		seq_flags[$past(ir.label[4:0])] == $past(ir.imm[0]))
		else $error("flag not written");
endmodule

// [tb/plc_model.sv]
`timescale 1ns/1ps
module plc_model (
	input  wire logic        pclk,                  // clock
	input  wire logic        presetn,               // async reset, low
	input  wire logic [2:0]  lag,                   // 0 prompt, up to 7 cycles slow
	input  wire logic [31:0] req_flags,             // flags the plc logic intends
	input  wire logic        program_end_pulse_bit, // end one-shot from sequencer
	output logic      [31:0] plc_flags,             // flags to sequencer
	output logic      [15:0] end_count              // cycles the end bit was seen high
);
	logic [31:0] pipe [0:6];

	// plc scan delay on flags the sequencer tests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 7; i++) pipe[i] <= '0;
		end else begin
			pipe[0] <= req_flags;
			for (int i = 1; i < 7; i++) pipe[i] <= pipe[i-1];
		end
	end
	assign plc_flags = (lag == 3'h0) ? req_flags : pipe[lag - 3'h1];

	// counts high cycles, so a stretched pulse shows as extra counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			end_count <= '0;
		else if (program_end_pulse_bit === 1'b1)
			end_count <= end_count + 16'h0001;
	end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import motion_seq_pkg::*;
	localparam int TK = 4;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = '0, plc_out_en = '0, plc_out_val = '0, phys_out;
	logic [31:0] pwdata = '0, phys_in = '0, req = '0, actual_pos = '0, cmd_pos = '0, ef, cr;
	logic [15:0] analog_in = '0, torque_cfg = '0, torque_limit, end_count;
	logic [31:0] prdata, plc_flags, seq_flags, follow_limit, inpos_band, soft_lim_lo, soft_lim_hi;
	logic        pready, pslverr, pend, running, fault, jog_enable;
	logic [19:0] follow_ratio;
	logic [2:0]  lag = 3'h3;
	logic [31:0] prog[$], expq[$], flt[$];
	string       nmq[$];
	int          errors = 0, n_compared = 0, ends = 0, seed = 32'h081a_f4e8, c, cyc[3], n;

	always #5 pclk = ~pclk;

	motion_program_sequencer #(.TICKS(TK)) motion_program_sequencer_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phys_in(phys_in), .plc_flags(plc_flags), .plc_out_en(plc_out_en),
		.plc_out_val(plc_out_val), .actual_pos(actual_pos), .cmd_pos(cmd_pos),
		.analog_in(analog_in), .torque_cfg(torque_cfg), .global_follow(32'h0000_0111),
		.global_inpos(32'h0000_0022), .phys_out(phys_out), .seq_flags(seq_flags),
		.program_end_pulse_bit(pend), .running(running), .fault(fault),
		.jog_enable(jog_enable), .torque_limit(torque_limit), .follow_limit(follow_limit),
		.inpos_band(inpos_band), .soft_lim_lo(soft_lim_lo), .soft_lim_hi(soft_lim_hi),
		.follow_ratio(follow_ratio));

	plc_model plc_model_inst (.pclk(pclk), .presetn(presetn), .lag(lag), .req_flags(req),
		.program_end_pulse_bit(pend), .plc_flags(plc_flags), .end_count(end_count));

	function automatic logic [31:0] ins(logic [4:0] op, logic [2:0] sb, logic [11:0] im,
		logic [7:0] lb, logic [3:0] rr = 4'h0);
		return {op, sb, rr, im, lb};
	endfunction

	function automatic logic cmpf(input int k, input int a, input int b);
		case (k)
			0: return a < b;
			1: return a > b;
			2: return a <= b;
			3: return a >= b;
			4: return a != b;
			default: return a == b;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			errors++;
			end_sim();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		expq.push_back(e);
		nmq.push_back(nm);
		apb(1'b0, a, '0);
	endtask

	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			if (expq.size() > 0)
				chk(nmq.pop_front(), expq.pop_front(), prdata);
		end
	end

	task automatic idle(output int k);
		k = 0;
		#1;
		while (running === 1'b1 && k < 70000) begin
			@(posedge pclk);
			#1;
			k++;
		end
		if (k >= 70000) begin
			errors++;
			end_sim();
		end
	endtask

	task automatic run(output int k);
		apb(1'b1, OFS_PADDR, '0);
		foreach (prog[i]) apb(1'b1, OFS_PDATA, prog[i]);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		idle(k);
	endtask

	// flag 9 shows whether the word under test took its branch to word 3
	task automatic brt(input logic [31:0] w, input logic tk);
		prog = '{ins(OP_SET_FLAG, 0, 0, 9), w, ins(OP_END, 0, 0, 0), ins(OP_SET_FLAG, 0, 1, 9),
			ins(OP_END, 0, 0, 0)};
		run(c);
		ends++;
		ef[9] = tk;
		rd(OFS_FLAGS, ef, "flags");
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, '0, "status");
		rd(OFS_OUTS, '0, "outs");
		rd(8'h30, '0, "unmapped");
		chk("slverr", 32'h1, {31'h0, pslverr});
		chk("lim_lo", 32'h8000_0000, soft_lim_lo);
		chk("follow", 32'h0000_0111, follow_limit);
		chk("inpos", 32'h0000_0022, inpos_band);
		chk("ratio", 32'h0000_2710, {12'h000, follow_ratio});
		$display("test reset done");
		cr = $random(seed);
		apb(1'b1, OFS_GPREG, cr);
		rd(OFS_GPREG, cr, "gpreg");
		apb(1'b1, OFS_GPREG + 8'h04, ~cr);
		plc_out_en <= 8'h08;
		prog = '{ins(OP_SET_OUT, 0, 1, 3), ins(OP_SET_OUT, 0, 1, 5), ins(OP_SET_OUT, 0, 1, 6),
			ins(OP_SET_OUT, 0, 0, 6), ins(OP_SET_FLAG, 0, 1, 31), ins(OP_SET_FLAG, 0, 1, 0),
			ins(OP_MULTI, 3'h3, 0, 0), ins(OP_MULTI, 3'h4, 0, 0, 4'h1), ins(OP_END, 0, 0, 0)};
		run(c);
		ends++;
		ef = 32'h8000_0001;
		ef[31:16] = (ef[31:16] & ~cr[31:16]) | (cr[15:0] & cr[31:16]);
		cr = ~cr;
		ef[23:16] = (ef[23:16] & ~cr[23:16]) | (cr[7:0] & cr[23:16]);
		rd(OFS_FLAGS, ef, "flags");
		rd(OFS_OUTS, 32'h0000_0020, "outs");
		plc_out_en <= 8'h00;
		rd(OFS_OUTS, 32'h0000_0028, "outs");
		chk("phys_out", 32'h0000_0028, {24'h00_0000, phys_out});
		$display("test outputs and flags done");
		brt(ins(OP_BRANCH, 0, 0, 3), 1'b1);
		cmd_pos <= 32'hFFFF_FF00;
		for (int k = 0; k < 6; k++) begin
			cr = $random(seed);
			cr = {30'h0, cr[1:0]} + 32'd4;
			actual_pos <= cr;
			brt(ins(OP_BR_POS, k[2:0], 12'h005, 3, 4'h1), cmpf(k, cr, 5));
		end
		brt(ins(OP_BR_POS, CMP_LT, 12'h005, 3, 4'h0), 1'b1);
		for (int j = 0; j < 8; j++) begin
			cr = $random(seed);
			phys_in <= cr;
			req <= ~cr;
			lag <= j[2] ? 3'h6 : 3'h0;
			brt(ins(j[2] ? OP_CALL_COND : OP_BR_COND, 0, {5'h0, j[1], 5'd4, j[0]}, 3),
				(j[0] ? ~cr[4] : cr[4]) == j[1]);
		end
		analog_in <= 16'hFFFD;
		brt(ins(OP_BR_ANALOG, CMP_LT, 0, 3), 1'b1);
		brt(ins(OP_BR_ANALOG, CMP_GT, 0, 3), 1'b0);
		apb(1'b1, OFS_GPREG + 8'h08, 32'h0000_0007);
		brt(ins(OP_BR_REG, CMP_EQ, 12'h007, 3, 4'h2), 1'b1);
		brt(ins(OP_BR_REG, CMP_NE, 12'h002, 3, 4'hA), 1'b0);
		$display("test branches done");
		for (int i = 0; i < 3; i++) begin
			n = (i == 0) ? 1 : 3;
			prog = '{ins(OP_LOOP_START, n[14:12], n[11:0], 0), ins(OP_CALL, 0, 0, 5),
				ins(OP_LOOP_END, 0, 0, 0), ins(OP_DELAY, 0, (i == 2) ? 3 : 1, 0),
				ins(OP_END, 0, 0, 0), ins(OP_RETURN, 0, 0, 0)};
			run(cyc[i]);
			ends++;
		end
		chk("loop", 32'd12, 32'(cyc[1] - cyc[0]));
		chk("delay", 32'(2 * TK), 32'(cyc[2] - cyc[1]));
		prog = '{ins(OP_CALL, 0, 0, 2), ins(OP_END, 0, 0, 0), ins(OP_CALL, 0, 0, 4),
			ins(OP_RETURN, 0, 0, 0), ins(OP_CALL, 0, 0, 6), ins(OP_RETURN, 0, 0, 0),
			ins(OP_CALL, 0, 0, 8), ins(OP_RETURN, 0, 0, 0), ins(OP_RETURN, 0, 0, 0)};
		run(c);
		ends++;
		chk("fault", 32'h0, {31'h0, fault});
		prog = '{ins(OP_LOOP_START, 0, 2, 0), ins(OP_LOOP_START, 0, 2, 0),
			ins(OP_LOOP_START, 0, 2, 0), ins(OP_LOOP_END, 0, 0, 0), ins(OP_LOOP_END, 0, 0, 0),
			ins(OP_LOOP_END, 0, 0, 0), ins(OP_END, 0, 0, 0)};
		run(c);
		ends++;
		chk("fault", 32'h0, {31'h0, fault});
		flt = '{ins(OP_CALL, 0, 0, 0), ins(OP_LOOP_START, 0, 1, 0), ins(OP_RETURN, 0, 0, 0),
			ins(OP_LOOP_END, 0, 0, 0), ins(OP_LOOP_START, 0, 0, 0),
			ins(OP_LOOP_START, 3'h2, 12'h711, 0), ins(OP_PARAM, PAR_RATIO, 0, 0)};
		foreach (flt[i]) begin
			prog = '{flt[i], ins(OP_BRANCH, 0, 0, 0)};
			run(c);
			chk("fault", 32'h1, {31'h0, fault});
			apb(1'b1, OFS_CTRL, 32'h0000_0001);
			idle(c);
			chk("blocked", 32'h0, 32'(c));
			apb(1'b1, OFS_CTRL, 32'h0000_0002);
			rd(OFS_STATUS, 32'h0000_0100, "status");
		end
		$display("test nesting and faults done");
		@(posedge pclk);
		phys_in <= '0;
		prog = '{ins(OP_WAIT, 0, 12'h0C4, 0), ins(OP_END, 0, 0, 0)};
		apb(1'b1, OFS_PADDR, '0);
		foreach (prog[i]) apb(1'b1, OFS_PDATA, prog[i]);
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		repeat (10) @(posedge pclk);
		#1;
		chk("waiting", 32'h3, {30'h0, running, jog_enable});
		@(posedge pclk);
		phys_in <= 32'h0000_0004;
		idle(c);
		ends++;
		chk("jog", 32'h0, {31'h0, jog_enable});
		@(posedge pclk);
		phys_in <= '0;
		torque_cfg <= 16'd1000;
		apb(1'b1, OFS_CTRL, 32'h0000_0001);
		apb(1'b1, OFS_CTRL, 32'h0000_0004);
		#1;
		chk("stopped", 32'h0, {31'h0, running});
		$display("test wait done");
		prog = '{ins(OP_TORQUE, 0, 12'd50, 0), ins(OP_PARAM, PAR_FOLLOW, 12'h123, 0),
			ins(OP_PARAM, PAR_INPOS, 12'h045, 0), ins(OP_PARAM, PAR_LIM_LO, 12'hF00, 0),
			ins(OP_PARAM, PAR_LIM_HI, 12'h7FF, 0), ins(OP_PARAM, PAR_RATIO, 12'h4D2, 0),
			ins(OP_END, 0, 0, 0)};
		run(c);
		ends++;
		chk("torque", 32'd500, {16'h0, torque_limit});
		chk("follow", 32'h0000_0123, follow_limit);
		chk("inpos", 32'h0000_0045, inpos_band);
		chk("lim_lo", 32'hFFFF_FF00, soft_lim_lo);
		chk("lim_hi", 32'h0000_07FF, soft_lim_hi);
		chk("ratio", 32'd1234, {12'h000, follow_ratio});
		$display("test parameters done");
		repeat (2) @(posedge pclk);
		chk("ends", 32'(ends), {16'h0, end_count});
		end_sim();
	end
endmodule
